// ==== frzid_pkg.sv ====
/*
  constants and state types shared by the freeze and identification register block.
  assumes a single system clock and an asynchronous active-low reset.
*/
`default_nettype none

package frzid_pkg;
  // printed register offsets; low 16 bits are the word index on the bus
  localparam logic [31:0] OFS_CHAR_FIRST = 32'h5000_3200;
  localparam logic [31:0] OFS_CHAR_SECOND = 32'h5000_3201;
  localparam logic [31:0] OFS_CHAR_THIRD = 32'h5000_3202;
  localparam logic [31:0] OFS_COMPAT = 32'h5000_3203;
  localparam logic [31:0] OFS_REVISION = 32'h5000_3204;
  localparam logic [31:0] OFS_FRZ_SET = 32'h5000_3300;
  localparam logic [31:0] OFS_FRZ_CLR = 32'h5000_3302;
  localparam logic [31:0] OFS_DBG_CTRL = 32'h5000_3304;
  // bus geometry: byte address bits [17:2] carry the word index
  localparam int ADDR_W = 18;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 16;
  localparam int DATA_W = 32;
  // field widths
  localparam int UNITS = 8;
  localparam int CHAR_W = 8;
  localparam int COMPAT_W = 4;
  // freeze bit positions
  localparam int BIT_TIMER_TWO = 7;
  localparam int BIT_TIMER_ONE = 6;
  localparam int BIT_DMA = 5;
  localparam int BIT_USB = 4;
  localparam int BIT_WATCHDOG = 3;
  localparam int BIT_RADIO_CLK = 2;
  localparam int BIT_TIMER_ZERO = 1;
  localparam int BIT_WAKEUP = 0;
  localparam int BIT_DBG_EN = 0;
  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic DBG_EN_RST = 1'b1;
  // only the watchdog position, used to force its freeze
  localparam logic [7:0] WDOG_MASK = 8'h08;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // bus slave state
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] idx;
    logic [15:0] data;
    logic [1:0] strb;
  } axi_st_type;

  localparam axi_st_type AXI_ST_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                        default: '0};

  // top-level state
  typedef struct packed {
    logic [7:0] freeze;
    logic dbg_en;
  } top_st_type;
endpackage : frzid_pkg

`default_nettype wire

// ==== freeze_flags.sv ====
/*
  sticky freeze flags, one per unit, set and cleared by per-unit bit vectors.
  assumes set and clear vectors are single-cycle and already byte-lane gated.
*/
`default_nettype none

module freeze_flags (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] set_vec, // ones freeze
  input wire logic [7:0] clr_vec, // ones resume
  input wire logic wdog_lock, // watchdog reset-only mode
  output logic [7:0] flags // sticky flags
);
  logic [7:0] flags_ff; // flag storage
  logic [7:0] nxt_flags; // next flags
  logic [7:0] set_eff; // set after watchdog gating

  // watchdog set ignored while locked, clear beats set
  always_comb begin
    set_eff = set_vec;
    set_eff[frzid_pkg::BIT_WATCHDOG] = set_vec[frzid_pkg::BIT_WATCHDOG] & ~wdog_lock;
    nxt_flags = (flags_ff | set_eff) & ~clr_vec;
  end

  // register flags; cleared to running at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= frzid_pkg::FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;

  chk_clear_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (set_vec[0] && clr_vec[0]) |=> !flags_ff[0])
    else $error("set overrode clear");
endmodule : freeze_flags

`default_nettype wire

// ==== axi_regport.sv ====
/*
  axi4-lite slave: up to two writes and one read in flight, word-indexed registers.
  assumes the register file answers reads and write errors combinationally.
*/
`default_nettype none

module axi_regport (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [17:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // response valid
  input wire logic bready, // response ready
  input wire logic [17:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read valid
  input wire logic rready, // read ready
  output logic wr_req, // write performed this cycle
  output logic [15:0] wr_idx, // write word index
  output logic [15:0] wr_data, // write data low half
  output logic [1:0] wr_strb, // low strobes
  input wire logic wr_err, // write to unmapped word
  output logic rd_fire, // read taken this cycle
  output logic [15:0] rd_idx, // read word index
  input wire logic [31:0] rd_data, // read word
  input wire logic rd_err // read of unmapped word
);
  frzid_pkg::axi_st_type st_ff; // registered state
  frzid_pkg::axi_st_type nxt_st; // next state

  assign wr_req = st_ff.aw_full & st_ff.w_full & ~st_ff.bvalid;
  assign rd_idx = araddr[17:2];
  assign rd_fire = arvalid & st_ff.arready;

  // handshake bookkeeping for both channels
  always_comb begin
    nxt_st = st_ff;
    if (awvalid && st_ff.awready) begin
      nxt_st.aw_full = 1'b1;
      nxt_st.idx = awaddr[17:2];
    end
    if (wvalid && st_ff.wready) begin
      nxt_st.w_full = 1'b1;
      nxt_st.data = wdata[15:0];
      nxt_st.strb = wstrb[1:0];
    end
    if (wr_req) begin
      nxt_st.aw_full = 1'b0;
      nxt_st.w_full = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wr_err ? frzid_pkg::RESP_SLVERR : frzid_pkg::RESP_OKAY;
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    nxt_st.awready = ~nxt_st.aw_full;
    nxt_st.wready = ~nxt_st.w_full;
    // read: answer is captured at the address handshake
    if (rd_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.arready = 1'b0;
      nxt_st.rdata = rd_data;
      nxt_st.rresp = rd_err ? frzid_pkg::RESP_SLVERR : frzid_pkg::RESP_OKAY;
    end
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= frzid_pkg::AXI_ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign awready = st_ff.awready;
  assign wready = st_ff.wready;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid = st_ff.rvalid;
  assign rdata = st_ff.rdata;
  assign rresp = st_ff.rresp;
  assign wr_idx = st_ff.idx;
  assign wr_data = st_ff.data;
  assign wr_strb = st_ff.strb;
endmodule : axi_regport

`default_nettype wire

// ==== frzid_regs.sv ====
/*
  identification registers and timer freeze controller behind an axi4-lite slave.
  assumes a synchronous debug-halt level from the processor and the
  watchdog reset-only mode level from the watchdog block.
*/
// The AXI4-Lite interface to the registers was left to the implementer.
`default_nettype none

// Behaviour
// - set-register ones freeze units, zeros ignored
// - bit7 timer2 down to bit0 wakeup
// - clear-register ones resume units, zeros ignored
// - watchdog freeze honoured only outside reset-only mode
// - debug enable resets one, halt freezes all
// - enable low: halt freezes others by flags
// - watchdog always frozen during debug halt
// - debug enable kept across sleep wake-up
// - three ascii device type characters, consecutive
// - four-bit compat code, upper nibble reserved
// - revision register returns uppercase ascii letter
// - sixteen-bit freeze/debug registers, reserved read zero
// - reset-only mode blocks software watchdog freeze
module frzid_regs #(
  parameter logic [7:0] ID_CHAR_FIRST = 8'h58, // arbitrary value
  parameter logic [7:0] ID_CHAR_SECOND = 8'h59, // arbitrary value
  parameter logic [7:0] ID_CHAR_THIRD = 8'h5a, // arbitrary value
  parameter logic [3:0] ID_COMPAT = 4'h3, // arbitrary value
  parameter logic [7:0] ID_REVISION = 8'h43 // arbitrary value
) (
  input wire logic CORE_CLK, // system clock, 100 mhz
  input wire logic RST_N, // async reset, active low
  input wire logic [17:0] AWADDR, // write byte address
  input wire logic AWVALID, // write address valid
  output logic AWREADY, // write address ready
  input wire logic [31:0] WDATA, // write data
  input wire logic [3:0] WSTRB, // write byte strobes
  input wire logic WVALID, // write data valid
  output logic WREADY, // write data ready
  output logic [1:0] BRESP, // write response code
  output logic BVALID, // write response valid
  input wire logic BREADY, // write response ready
  input wire logic [17:0] ARADDR, // read byte address
  input wire logic ARVALID, // read address valid
  output logic ARREADY, // read address ready
  output logic [31:0] RDATA, // read data
  output logic [1:0] RRESP, // read response code
  output logic RVALID, // read valid
  input wire logic RREADY, // read ready
  input wire logic CPU_DEBUG_HALT, // processor halted in debug
  input wire logic WDOG_RST_ONLY, // watchdog reset-only mode
  output logic [7:0] FREEZE_OUT, // per-unit freeze, 1 = frozen
  output logic DEBUG_FREEZE_EN // debug halt freeze enable
);
  // register-side view of the slave
  logic wr_req; // write performed this cycle
  logic [15:0] wr_idx; // write word index
  logic [15:0] wr_data; // write data low half
  logic [1:0] wr_strb; // low byte strobes
  logic wr_err; // write hits no register
  logic rd_fire; // read taken this cycle
  logic [15:0] rd_idx; // read word index
  logic [31:0] rd_data; // read word
  logic rd_err; // read hits no register
  // freeze flag interface
  logic [7:0] set_vec; // freeze request vector
  logic [7:0] clr_vec; // resume request vector
  logic [7:0] flags; // sticky software freeze flags
  // top state
  frzid_pkg::top_st_type st_ff; // registered outputs
  frzid_pkg::top_st_type nxt_st; // next outputs
  logic [7:0] wdog_keep; // masks the watchdog flag out of the outputs while locked

  // true when a word index names one of our registers
  function automatic logic is_mapped(input logic [15:0] idx);
    is_mapped = (idx == frzid_pkg::OFS_CHAR_FIRST[15:0]) ||
                (idx == frzid_pkg::OFS_CHAR_SECOND[15:0]) ||
                (idx == frzid_pkg::OFS_CHAR_THIRD[15:0]) ||
                (idx == frzid_pkg::OFS_COMPAT[15:0]) ||
                (idx == frzid_pkg::OFS_REVISION[15:0]) ||
                (idx == frzid_pkg::OFS_FRZ_SET[15:0]) ||
                (idx == frzid_pkg::OFS_FRZ_CLR[15:0]) ||
                (idx == frzid_pkg::OFS_DBG_CTRL[15:0]);
  endfunction : is_mapped

  // true for a write-side hit on one register with byte lane 0 enabled
  function automatic logic lane_hit(input logic req, input logic [1:0] strb,
                                    input logic [15:0] idx, input logic [31:0] ofs);
    lane_hit = req && strb[0] && (idx == ofs[15:0]);
  endfunction : lane_hit

  // axi4-lite slave
  axi_regport u_port (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .awaddr(AWADDR),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .wvalid(WVALID),
    .wready(WREADY),
    .bresp(BRESP),
    .bvalid(BVALID),
    .bready(BREADY),
    .araddr(ARADDR),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .rvalid(RVALID),
    .rready(RREADY),
    .wr_req(wr_req),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_fire(rd_fire),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // sticky freeze flags
  freeze_flags u_flags (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .set_vec(set_vec),
    .clr_vec(clr_vec),
    .wdog_lock(WDOG_RST_ONLY),
    .flags(flags)
  );

  // write decode: set and clear registers act only on written ones
  always_comb begin
    set_vec = '0;
    clr_vec = '0;
    if (lane_hit(wr_req, wr_strb, wr_idx, frzid_pkg::OFS_FRZ_SET)) begin
      set_vec = wr_data[7:0];
    end else if (lane_hit(wr_req, wr_strb, wr_idx, frzid_pkg::OFS_FRZ_CLR)) begin
      clr_vec = wr_data[7:0];
    end
    // unmapped words answer with an error, read-only words ignore writes
    wr_err = !is_mapped(wr_idx);
  end

  // read decode: narrow registers sit in the low bits, the rest reads zero
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (rd_idx == frzid_pkg::OFS_CHAR_FIRST[15:0]) begin
      rd_data[7:0] = ID_CHAR_FIRST;
    end else if (rd_idx == frzid_pkg::OFS_CHAR_SECOND[15:0]) begin
      rd_data[7:0] = ID_CHAR_SECOND;
    end else if (rd_idx == frzid_pkg::OFS_CHAR_THIRD[15:0]) begin
      rd_data[7:0] = ID_CHAR_THIRD;
    end else if (rd_idx == frzid_pkg::OFS_COMPAT[15:0]) begin
      rd_data[3:0] = ID_COMPAT;
    end else if (rd_idx == frzid_pkg::OFS_REVISION[15:0]) begin
      rd_data[7:0] = ID_REVISION;
    end else if (rd_idx == frzid_pkg::OFS_FRZ_SET[15:0]) begin
      rd_data[7:0] = flags;
    end else if (rd_idx == frzid_pkg::OFS_FRZ_CLR[15:0]) begin
      rd_data[7:0] = flags;
    end else if (rd_idx == frzid_pkg::OFS_DBG_CTRL[15:0]) begin
      rd_data[frzid_pkg::BIT_DBG_EN] = st_ff.dbg_en;
    end else begin
      rd_err = 1'b1; // unmapped word
    end
  end

  // freeze outputs and debug enable
  always_comb begin
    nxt_st = st_ff;
    // debug enable changes only by a bus write
    if (lane_hit(wr_req, wr_strb, wr_idx, frzid_pkg::OFS_DBG_CTRL)) begin
      nxt_st.dbg_en = wr_data[frzid_pkg::BIT_DBG_EN];
    end
    // locked watchdog ignores its software flag
    wdog_keep = ~(WDOG_RST_ONLY ? frzid_pkg::WDOG_MASK : 8'h00);
    nxt_st.freeze = flags & wdog_keep;
    if (CPU_DEBUG_HALT) begin
      if (st_ff.dbg_en) begin
        nxt_st.freeze = '1;
      end else begin
        nxt_st.freeze = (flags & wdog_keep) | frzid_pkg::WDOG_MASK;
      end
    end
  end

  // state register; only the system reset reloads the debug enable, so a
  // retained domain keeps it across sleep
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff.freeze <= frzid_pkg::FLAGS_RST;
      st_ff.dbg_en <= frzid_pkg::DBG_EN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign FREEZE_OUT = st_ff.freeze;
  assign DEBUG_FREEZE_EN = st_ff.dbg_en;

  // checks, all in the system clock domain
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  // a set write freezes the named unit
  chk_set_freezes: assert property (
    (set_vec[frzid_pkg::BIT_TIMER_ZERO] && !clr_vec[frzid_pkg::BIT_TIMER_ZERO])
      |=> flags[frzid_pkg::BIT_TIMER_ZERO])
    else $error("set did not freeze timer zero");

  // flags hold while nothing lands
  chk_idle_stable: assert property (
    (set_vec == 8'h00 && clr_vec == 8'h00) |=> $stable(flags))
    else $error("flags moved without a write");

  // a clear write resumes the named unit
  chk_clear_resumes: assert property (
    clr_vec[frzid_pkg::BIT_TIMER_TWO] |=> !flags[frzid_pkg::BIT_TIMER_TWO])
    else $error("clear did not resume timer two");

  // a locked watchdog ignores its set bit
  chk_wdog_locked_set: assert property (
    (set_vec[frzid_pkg::BIT_WATCHDOG] && WDOG_RST_ONLY)
      |=> $stable(flags[frzid_pkg::BIT_WATCHDOG]))
    else $error("locked watchdog accepted a freeze");

  // lock masks the watchdog output
  chk_wdog_lock_out: assert property (
    (WDOG_RST_ONLY && !CPU_DEBUG_HALT) |=> !FREEZE_OUT[frzid_pkg::BIT_WATCHDOG])
    else $error("locked watchdog frozen by software");

  // halt with enable set stops all
  chk_halt_all: assert property (
    (CPU_DEBUG_HALT && st_ff.dbg_en) |=> (FREEZE_OUT == 8'hff))
    else $error("debug halt did not freeze all units");

  // halt with enable clear follows flags
  chk_halt_flags: assert property (
    (CPU_DEBUG_HALT && !st_ff.dbg_en && !WDOG_RST_ONLY)
      |=> (FREEZE_OUT == ($past(flags) | frzid_pkg::WDOG_MASK)))
    else $error("halt freeze not by flags");

  // watchdog always stops on a halt
  chk_halt_wdog: assert property (
    CPU_DEBUG_HALT |=> FREEZE_OUT[frzid_pkg::BIT_WATCHDOG])
    else $error("watchdog ran during debug halt");

  // only a bus write moves the enable
  chk_dbg_retained: assert property (
    !lane_hit(wr_req, wr_strb, wr_idx, frzid_pkg::OFS_DBG_CTRL) |=> $stable(st_ff.dbg_en))
    else $error("debug enable changed without a write");

  // identification words, low byte
  chk_id_first: assert property (
    (rd_fire && rd_idx == frzid_pkg::OFS_CHAR_FIRST[15:0]) |=> (RDATA == {24'h00_0000, ID_CHAR_FIRST}))
    else $error("first character read wrong");

  // compat upper bits read zero
  chk_compat_hi: assert property (
    (rd_fire && rd_idx == frzid_pkg::OFS_COMPAT[15:0]) |=> (RDATA[31:4] == 28'h000_0000))
    else $error("compat upper bits not zero");

  // revision letter, low byte
  chk_revision: assert property (
    (rd_fire && rd_idx == frzid_pkg::OFS_REVISION[15:0]) |=> (RDATA[7:0] == ID_REVISION))
    else $error("revision read wrong");

  // debug word zero above bit zero
  chk_dbg_reserved: assert property (
    (rd_fire && rd_idx == frzid_pkg::OFS_DBG_CTRL[15:0]) |=> (RDATA[31:1] == 31'h0000_0000))
    else $error("debug reserved bits not zero");

  // clear register reads the flags
  chk_flags_read: assert property (
    (rd_fire && rd_idx == frzid_pkg::OFS_FRZ_CLR[15:0]) |=> (RDATA[7:0] == $past(flags)))
    else $error("clear register did not show flags");

  // set register reads the flags
  chk_set_reg_read: assert property (
    (rd_fire && rd_idx == frzid_pkg::OFS_FRZ_SET[15:0]) |=> (RDATA[7:0] == $past(flags)))
    else $error("set register did not show flags");

  chk_set_reserved: assert property (
    (rd_fire && rd_idx == frzid_pkg::OFS_FRZ_SET[15:0]) |=> (RDATA[31:8] == 24'h00_0000))
    else $error("set reserved bits not zero");

  // other identification words
  chk_id_second: assert property (
    (rd_fire && rd_idx == frzid_pkg::OFS_CHAR_SECOND[15:0])
      |=> (RDATA == {24'h00_0000, ID_CHAR_SECOND}))
    else $error("second character read wrong");

  chk_id_third: assert property (
    (rd_fire && rd_idx == frzid_pkg::OFS_CHAR_THIRD[15:0])
      |=> (RDATA == {24'h00_0000, ID_CHAR_THIRD}))
    else $error("third character read wrong");

  chk_compat_code: assert property (
    (rd_fire && rd_idx == frzid_pkg::OFS_COMPAT[15:0]) |=> (RDATA[3:0] == ID_COMPAT))
    else $error("compat code read wrong");

  // running, unlocked: outputs follow flags
  chk_run_mapping: assert property (
    (!CPU_DEBUG_HALT && !WDOG_RST_ONLY) |=> (FREEZE_OUT == $past(flags)))
    else $error("freeze outputs not in flag order");

  // zeros in set or clear words are ignored
  chk_set_zero_kept: assert property (
    (set_vec != 8'h00 && !set_vec[frzid_pkg::BIT_WAKEUP])
      |=> (flags[frzid_pkg::BIT_WAKEUP] == $past(flags[frzid_pkg::BIT_WAKEUP])))
    else $error("set zero changed wake-up flag");

  chk_clr_zero_kept: assert property (
    (clr_vec != 8'h00 && !clr_vec[frzid_pkg::BIT_DMA])
      |=> (flags[frzid_pkg::BIT_DMA] == $past(flags[frzid_pkg::BIT_DMA])))
    else $error("clear zero changed dma flag");

  // debug write loads bit zero
  chk_dbg_write: assert property (
    lane_hit(wr_req, wr_strb, wr_idx, frzid_pkg::OFS_DBG_CTRL)
      |=> (st_ff.dbg_en == $past(wr_data[frzid_pkg::BIT_DBG_EN])))
    else $error("debug enable write lost");

  // unmapped words are refused
  chk_read_refused: assert property (
    (rd_fire && rd_err) |=> (RRESP == frzid_pkg::RESP_SLVERR && RDATA == 32'h0000_0000))
    else $error("unmapped read not refused");

  chk_write_refused: assert property (
    (wr_req && wr_err) |=> (BVALID && BRESP == frzid_pkg::RESP_SLVERR))
    else $error("unmapped write not refused");

  // main scenarios to reach
  cov_set_write: cover property (set_vec != 8'h00);
  cov_unmapped_read: cover property (rd_fire && rd_err);
  cov_halt_enabled: cover property (CPU_DEBUG_HALT && st_ff.dbg_en);
  cov_halt_flags: cover property (CPU_DEBUG_HALT && !st_ff.dbg_en && flags != 8'h00);
  cov_locked_set: cover property (set_vec[frzid_pkg::BIT_WATCHDOG] && WDOG_RST_ONLY);
endmodule : frzid_regs

`default_nettype wire

// ==== tb_frzid_regs.sv ====
/*
  self-checking bench for the freeze and identification register block.
  assumes an axi4-lite slave with flop outputs; outputs are read at the falling
  edge, where they are settled, and acted on at the next rising edge.
*/
`default_nettype none

`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch %0t %s", $time, msg); end end

module tb_frzid_regs;
  timeunit 1ns;
  timeprecision 100ps;
  // arbitrary identification values handed to the block
  localparam logic [7:0] C1 = 8'h51; // arbitrary value
  localparam logic [7:0] C2 = 8'h52; // arbitrary value
  localparam logic [7:0] C3 = 8'h53; // arbitrary value
  localparam logic [3:0] CMP = 4'h5; // arbitrary value
  localparam logic [7:0] REV = 8'h44; // arbitrary value
  localparam int LIMIT = 100; // bound on every bus wait

  logic core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, cpu_debug_halt, wdog_rst_only;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, d;
  logic [3:0] wstrb, s;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] freeze_out, flags_m, exp_o; // flags_m: bench model of the sticky flags
  logic debug_freeze_en, en_m; // en_m: model of the debug halt enable
  int fail_count, total_checks, op, seed_dummy;
  logic [31:0] ofs_t [5];
  logic [7:0] exp_t [5];

  frzid_regs #(.ID_CHAR_FIRST(C1), .ID_CHAR_SECOND(C2), .ID_CHAR_THIRD(C3),
    .ID_COMPAT(CMP), .ID_REVISION(REV)) i_dut (
    .CORE_CLK(core_clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .CPU_DEBUG_HALT(cpu_debug_halt), .WDOG_RST_ONLY(wdog_rst_only),
    .FREEZE_OUT(freeze_out), .DEBUG_FREEZE_EN(debug_freeze_en));

  // 100 mhz clock
  always #5 core_clk = ~core_clk;

  // verdict and end of run
  task summarize();
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // a wait that ran out of its bound
  task expired();
    fail_count++;
    $display("mismatch %0t bus wait expired", $time);
    summarize();
  endtask : expired

  // word index sits in byte address bits [17:2]
  function automatic logic [17:0] byte_of(input logic [31:0] ofs);
    return {ofs[15:0], 2'b00};
  endfunction : byte_of

  // one axi write; address and data offered together, each released when taken
  task bus_write(input logic [17:0] a, input logic [31:0] dat, input logic [3:0] st,
                 output logic [1:0] r);
    int n;
    logic aw_hs, w_hs, b_hs;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dat;
    wstrb <= st;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < LIMIT; n++) begin
      // sample settled at the falling edge, act at the rising edge after it
      @(negedge core_clk);
      aw_hs = awvalid && awready === 1'b1;
      w_hs = wvalid && wready === 1'b1;
      b_hs = bvalid === 1'b1;
      if (b_hs) r = bresp;
      @(posedge core_clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == LIMIT) expired();
    @(posedge core_clk);
  endtask : bus_write

  // one axi read; rready held until rvalid is seen
  task bus_read(input logic [17:0] a, output logic [31:0] dat, output logic [1:0] r);
    int n;
    logic ar_hs, r_hs;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < LIMIT; n++) begin
      @(negedge core_clk);
      ar_hs = arvalid && arready === 1'b1;
      r_hs = rvalid === 1'b1;
      if (r_hs) dat = rdata;
      if (r_hs) r = rresp;
      @(posedge core_clk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == LIMIT) expired();
    @(posedge core_clk);
  endtask : bus_read

  // reset for eight cycles and reload the model
  task reset_dut();
    rst_n <= 1'b0;
    cpu_debug_halt <= 1'b0; // no halt across reset release
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    flags_m = 8'h00;
    en_m = 1'b1;
    `CHK(awready, 1'b1, "awready after reset")
    `CHK(bvalid, 1'b0, "bvalid after reset")
    `CHK(rvalid, 1'b0, "rvalid after reset")
  endtask : reset_dut

  // compare freeze outputs and the set, clear and debug registers with the model
  task check_state();
    exp_o = flags_m & ~(wdog_rst_only ? 8'h08 : 8'h00);
    if (cpu_debug_halt && en_m) exp_o = 8'hff;
    else if (cpu_debug_halt) exp_o = exp_o | 8'h08;
    // outputs trail their inputs by one registered stage; read them settled
    @(posedge core_clk);
    @(negedge core_clk);
    `CHK(freeze_out, exp_o, "freeze out")
    `CHK(debug_freeze_en, en_m, "debug enable")
    @(posedge core_clk);
    bus_read(byte_of(frzid_pkg::OFS_FRZ_SET), rd, resp);
    `CHK(rd, {24'h00_0000, flags_m}, "set reg read")
    `CHK(resp, frzid_pkg::RESP_OKAY, "set reg resp")
    bus_read(byte_of(frzid_pkg::OFS_FRZ_CLR), rd, resp);
    `CHK(rd, {24'h00_0000, flags_m}, "clear reg read")
    bus_read(byte_of(frzid_pkg::OFS_DBG_CTRL), rd, resp);
    `CHK(rd, {31'h0000_0000, en_m}, "debug reg read")
  endtask : check_state

  // main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, cpu_debug_halt, wdog_rst_only} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    fail_count = 0;
    total_checks = 0;
    seed_dummy = $urandom(91);
    reset_dut();
    check_state();
    // identification registers, read in address order
    ofs_t = '{frzid_pkg::OFS_CHAR_FIRST, frzid_pkg::OFS_CHAR_SECOND,
              frzid_pkg::OFS_CHAR_THIRD, frzid_pkg::OFS_COMPAT, frzid_pkg::OFS_REVISION};
    exp_t = '{C1, C2, C3, {4'h0, CMP}, REV};
    for (int i = 0; i < 5; i++) begin
      bus_read(byte_of(ofs_t[i]), rd, resp);
      `CHK(rd, {24'h00_0000, exp_t[i]}, "id read")
      `CHK(resp, frzid_pkg::RESP_OKAY, "id resp")
    end
    // write to a read-only word is accepted and ignored
    bus_write(byte_of(frzid_pkg::OFS_CHAR_FIRST), 32'hffff_ffff, 4'hf, resp);
    `CHK(resp, frzid_pkg::RESP_OKAY, "id write resp")
    bus_read(byte_of(frzid_pkg::OFS_CHAR_FIRST), rd, resp);
    `CHK(rd, {24'h00_0000, C1}, "id after write")
    // unmapped word between the set and clear registers
    bus_write(byte_of(32'h5000_3301), 32'h0000_00ff, 4'hf, resp);
    `CHK(resp, frzid_pkg::RESP_SLVERR, "unmapped write resp")
    bus_read(byte_of(32'h5000_3301), rd, resp);
    `CHK(resp, frzid_pkg::RESP_SLVERR, "unmapped read resp")
    `CHK(rd, 32'h0000_0000, "unmapped read data")
    check_state();
    // random set, clear and debug writes under random halt and lock levels
    for (int k = 0; k < 60; k++) begin
      cpu_debug_halt <= 1'($urandom % 2);
      wdog_rst_only <= 1'($urandom % 2);
      @(posedge core_clk);
      op = $urandom % 3;
      d = $urandom;
      s = 4'($urandom);
      case (op)
        0: begin
          bus_write(byte_of(frzid_pkg::OFS_FRZ_SET), d, s, resp);
          if (s[0]) flags_m = flags_m | (d[7:0] & ~(wdog_rst_only ? 8'h08 : 8'h00));
        end
        1: begin
          bus_write(byte_of(frzid_pkg::OFS_FRZ_CLR), d, s, resp);
          if (s[0]) flags_m = flags_m & ~d[7:0];
        end
        default: begin
          bus_write(byte_of(frzid_pkg::OFS_DBG_CTRL), d, s, resp);
          if (s[0]) en_m = d[0];
        end
      endcase
      `CHK(resp, frzid_pkg::RESP_OKAY, "write resp")
      check_state();
    end
    // a second reset in mid-run restores the reset state
    reset_dut();
    check_state();
    summarize();
  end
endmodule : tb_frzid_regs

`default_nettype wire
